// [bench/usbfi_line_model.sv]
// serial line partner: sends frames into the uart, decodes its output
// assumes 8 data bits, one stop bit and a divisor fixed by the bench
`timescale 1ns/1ps
module usbfi_line_model #(
	parameter int DIV = 2
) (
	// clock
	input wire logic core_clk,
	// serial line
	input wire logic sout,
	output logic serial_input_pin
);
	localparam int BT = 16 * DIV; // clocks per bit
	logic [7:0] rx_q[$]; // bytes decoded from sout
	logic [9:0] sh; // frame being decoded
	// line rests at mark
	initial serial_input_pin = 1'b1;
	// hold a level for n bit times, changed just after an edge
	task automatic hold(input logic v, input int n);
		serial_input_pin <= v;
		repeat (n * BT) @(posedge core_clk);
	endtask : hold
	// one frame, lsb first; par adds odd parity, bad inverts it
	task automatic send(input logic [7:0] d, input logic par,
		input logic bad);
		@(posedge core_clk);
		hold(1'b0, 1);
		for (int i = 0; i < 8; i++) begin
			hold(d[i], 1);
		end
		if (par) begin
			hold(~^d ^ bad, 1);
		end
		hold(1'b1, 2);
	endtask : send
	// break: low for two whole frames, then back to mark
	task automatic brk();
		@(posedge core_clk);
		hold(1'b0, 20);
		hold(1'b1, 2);
	endtask : brk
	// mid-bit sampling; no wait after stop so frames may follow closely
	always begin
		@(negedge sout);
		repeat (BT / 2) @(posedge core_clk);
		for (int i = 0; i < 10; i++) begin
			sh[i] = sout;
			if (i < 9) begin
				repeat (BT) @(posedge core_clk);
			end
		end
		// a bad frame is dropped, so chk_tx finds the queue empty and its check fails
		if (sh[0] == 1'b0 && sh[9] == 1'b1) begin
			rx_q.push_back(sh[8:1]);
		end
	end
endmodule : usbfi_line_model

// [bench/usbfi_uart_test.sv]
// self-checking bench for the uart status, baud, fifo and irq block
// assumes the line model on the serial pins; modem pins driven here
`timescale 1ns/1ps
`include "usbfi_params.svh"
module usbfi_uart_test;
	localparam int DIV = 2; // short divisor keeps frames brief
	localparam int CHR = 160 * DIV; // clocks per 8n1 character
	// clock, reset and register port
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [2:0] addr = 3'h0;
	logic rd_stb = 1'b0;
	logic wr_stb = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic intr;
	// serial and modem pins
	logic sin_w;
	logic sout;
	logic cts_n = 1'b1;
	logic dsr_n = 1'b1;
	logic ri_n = 1'b1;
	logic dcd_n = 1'b1;
	logic dtr_n;
	logic rts_n;
	logic aux1_n;
	logic aux2_n;
	// bookkeeping
	int err_count = 0;
	int samples_checked = 0;
	int seed = 32'hbcec;
	logic rd_d = 1'b0; // a read was taken at the last edge
	logic [7:0] exp_q[$]; // pending read notes
	logic [7:0] msk_q[$];
	string nam_q[$];
	logic [7:0] rx_exp[$]; // bytes sent into the receiver
	logic [7:0] b;
	logic [7:0] got;
	always #5 core_clk = ~core_clk;
	usbfi_uart usbfi_uart_i (.core_clk(core_clk), .sys_rst(sys_rst),
		.addr(addr), .rd_stb(rd_stb), .wr_stb(wr_stb), .wdata(wdata),
		.rdata(rdata), .intr(intr), .serial_input_pin(sin_w),
		.sout(sout), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
		.dcd_n(dcd_n), .dtr_n(dtr_n), .rts_n(rts_n),
		.aux_output_one_n(aux1_n), .aux_output_two_n(aux2_n));
	usbfi_line_model #(.DIV(DIV)) usbfi_line_model_i (
		.core_clk(core_clk), .sout(sout), .serial_input_pin(sin_w));
	// compare and count
	task automatic check(input string n, input logic [7:0] e,
		input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : check
	// one write strobe
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge core_clk);
		wr_stb <= 1'b0;
	endtask : wr
	// one read strobe; the expectation waits in the queue
	task automatic rd(input logic [2:0] a, input logic [7:0] e,
		input logic [7:0] m, input string n);
		@(posedge core_clk);
		addr <= a;
		rd_stb <= 1'b1;
		exp_q.push_back(e);
		msk_q.push_back(m);
		nam_q.push_back(n);
		@(posedge core_clk);
		rd_stb <= 1'b0;
	endtask : rd
	// read watcher: rdata settles one edge after the strobe
	always @(posedge core_clk) begin : watch
		logic [7:0] m;
		if (rd_d) begin
			m = msk_q.pop_front();
			check(nam_q.pop_front(), exp_q.pop_front() & m, rdata & m);
		end
		rd_d <= rd_stb;
	end
	// random byte into the receiver, then time to reach the fifo
	task automatic send_rx(input logic par, input logic bad);
		b = 8'($random(seed));
		usbfi_line_model_i.send(b, par, bad);
		rx_exp.push_back(b);
		repeat (16) @(posedge core_clk);
	endtask : send_rx
	// read the oldest received byte
	task automatic rd_rx();
		rd(`USBFI_ADR_DATA, rx_exp.pop_front(), 8'hff, "rx byte");
	endtask : rd_rx
	// interrupt pin after the edge's updates land
	task automatic chk_intr(input logic e, input string n);
		#1;
		check(n, {7'h00, e}, {7'h00, intr});
	endtask : chk_intr
	// oldest byte decoded from the line against the last byte written
	task automatic chk_tx(input string n);
		got = usbfi_line_model_i.rx_q.size()
			? usbfi_line_model_i.rx_q.pop_front() : 8'hxx;
		check(n, b, got);
	endtask : chk_tx
	// counts, verdict and end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize
	// watchdog, well beyond the expected run length
	initial begin
		repeat (100 * CHR) @(posedge core_clk);
		err_count++;
		summarize();
	end
	// main sequence
	initial begin
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(`USBFI_ADR_MSR, 8'h00, 8'h00, "msr flush");
		rd(`USBFI_ADR_SCR, 8'h00, 8'hff, "scratch");
		b = 8'($random(seed));
		wr(`USBFI_ADR_SCR, b);
		rd(`USBFI_ADR_SCR, b, 8'hff, "scratch");
		wr(`USBFI_ADR_LCR, 8'h83);
		wr(`USBFI_ADR_DATA, 8'(DIV));
		wr(`USBFI_ADR_IER, 8'h00);
		rd(`USBFI_ADR_DATA, 8'(DIV), 8'hff, "dll");
		rd(`USBFI_ADR_IER, 8'h00, 8'hff, "dlm");
		wr(`USBFI_ADR_LCR, 8'h03);
		wr(`USBFI_ADR_IIR, 8'h01);
		rd(`USBFI_ADR_LSR, 8'h60, 8'h61, "lsr idle");
		// transmit one byte at the programmed rate
		b = 8'($random(seed));
		wr(`USBFI_ADR_DATA, b);
		rd(`USBFI_ADR_LSR, 8'h00, 8'h40, "lsr busy");
		for (int k = 0; k < 4 * CHR && usbfi_line_model_i.rx_q.size() == 0;
			k++) begin
			@(posedge core_clk);
		end
		chk_tx("tx byte");
		repeat (CHR) @(posedge core_clk);
		rd(`USBFI_ADR_LSR, 8'h60, 8'h60, "lsr done");
		// plain receive
		send_rx(1'b0, 1'b0);
		rd(`USBFI_ADR_LSR, 8'h01, 8'h9f, "lsr rx");
		rd_rx();
		rd(`USBFI_ADR_LSR, 8'h00, 8'h01, "lsr empty");
		// parity error, odd parity
		wr(`USBFI_ADR_LCR, 8'h0b);
		send_rx(1'b1, 1'b1);
		rd(`USBFI_ADR_LSR, 8'h85, 8'h9f, "lsr parity");
		rd_rx();
		rd(`USBFI_ADR_LSR, 8'h00, 8'h9c, "lsr cleared");
		wr(`USBFI_ADR_LCR, 8'h03);
		// break: one zero entry, then a fresh start is needed
		usbfi_line_model_i.brk();
		repeat (16) @(posedge core_clk);
		rd(`USBFI_ADR_LSR, 8'h99, 8'h9f, "lsr break");
		rd(`USBFI_ADR_DATA, 8'h00, 8'hff, "break char");
		rd(`USBFI_ADR_LSR, 8'h00, 8'h01, "lsr one zero");
		send_rx(1'b0, 1'b0);
		rd_rx();
		// trigger level four, then character timeout
		wr(`USBFI_ADR_IIR, 8'h41);
		wr(`USBFI_ADR_IER, 8'h01);
		for (int i = 0; i < 4; i++) begin
			if (i == 3)
				chk_intr(1'b0, "intr below level");
			send_rx(1'b0, 1'b0);
		end
		chk_intr(1'b1, "intr at level");
		rd(`USBFI_ADR_IIR, 8'hc4, 8'hff, "iir data");
		rd_rx();
		repeat (3) @(posedge core_clk);
		chk_intr(1'b0, "intr drop");
		repeat (3 * CHR) @(posedge core_clk);
		chk_intr(1'b0, "intr early");
		repeat (2 * CHR) @(posedge core_clk);
		chk_intr(1'b1, "intr timeout");
		rd(`USBFI_ADR_IIR, 8'hcc, 8'hff, "iir timeout");
		rd_rx();
		repeat (3) @(posedge core_clk);
		chk_intr(1'b0, "timeout clear");
		rd_rx();
		rd_rx();
		// polled mode: fifo stores, nothing reported
		wr(`USBFI_ADR_IER, 8'h00);
		send_rx(1'b0, 1'b0);
		repeat (5 * CHR) @(posedge core_clk);
		chk_intr(1'b0, "polled intr");
		rd(`USBFI_ADR_LSR, 8'h01, 8'h01, "polled lsr");
		rd_rx();
		// transmit request: first one at once, then the delayed one
		wr(`USBFI_ADR_IER, 8'h02);
		repeat (3) @(posedge core_clk);
		chk_intr(1'b1, "tx_holding_empty first");
		rd(`USBFI_ADR_IIR, 8'hc2, 8'hff, "iir tx_holding_empty");
		repeat (3) @(posedge core_clk);
		chk_intr(1'b0, "tx_holding_empty read clear");
		b = 8'($random(seed));
		wr(`USBFI_ADR_DATA, b);
		repeat (100) @(posedge core_clk);
		chk_intr(1'b0, "tx_holding_empty held back");
		repeat (300) @(posedge core_clk);
		chk_intr(1'b1, "tx_holding_empty after delay");
		chk_tx("tx fifo byte");
		rd(`USBFI_ADR_IIR, 8'hc2, 8'hff, "iir tx_holding_empty late");
		repeat (1200) @(posedge core_clk);
		chk_intr(1'b0, "tx_holding_empty stays clear");
		wr(`USBFI_ADR_IER, 8'h00);
		// modem inputs
		@(posedge core_clk);
		cts_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		rd(`USBFI_ADR_MSR, 8'h11, 8'hff, "msr cts");
		rd(`USBFI_ADR_MSR, 8'h10, 8'hff, "msr clear");
		ri_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		ri_n <= 1'b1;
		repeat (6) @(posedge core_clk);
		rd(`USBFI_ADR_MSR, 8'h14, 8'hff, "msr ring");
		dsr_n <= 1'b0;
		dcd_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		rd(`USBFI_ADR_MSR, 8'hba, 8'hff, "msr dsr dcd");
		// loopback: status follows the control bits
		for (int i = 0; i < 4; i++) begin
			b = 8'($random(seed));
			wr(`USBFI_ADR_MCR, {4'h1, b[3:0]});
			repeat (6) @(posedge core_clk);
			check("loop pins", 8'h0f,
				{4'h0, dtr_n, rts_n, aux1_n, aux2_n});
			rd(`USBFI_ADR_MSR, {b[3], b[2], b[0], b[1], 4'h0}, 8'hf0,
				"msr loop");
		end
		// out of loopback the pins follow the control bits again
		wr(`USBFI_ADR_MCR, {4'h0, b[3:0]});
		repeat (3) @(posedge core_clk);
		check("modem pins", {4'h0, ~b[0], ~b[1], ~b[2], ~b[3]},
			{4'h0, dtr_n, rts_n, aux1_n, aux2_n});
		repeat (4) @(posedge core_clk);
		summarize();
	end
endmodule : usbfi_uart_test

// [hw/usbfi_params.svh]
// constants for the uart status, baud, fifo and interrupt block
// assumes byte-wide register port with three address lines
`ifndef USBFI_PARAMS_SVH
`define USBFI_PARAMS_SVH
// register addresses
`define USBFI_ADR_DATA 3'h0
`define USBFI_ADR_IER 3'h1
`define USBFI_ADR_IIR 3'h2
`define USBFI_ADR_LCR 3'h3
`define USBFI_ADR_MCR 3'h4
`define USBFI_ADR_LSR 3'h5
`define USBFI_ADR_MSR 3'h6
`define USBFI_ADR_SCR 3'h7
// reset values
`define USBFI_DIV_RST 16'h0001
`define USBFI_LCR_RST 8'h03
// field positions
`define USBFI_LCR_DIVISOR_ACCESS_SELECT 7
`define USBFI_LCR_BRK 6
`define USBFI_MCR_LOOP 4
`define USBFI_IER_EXT 5
// interrupt identification codes
`define USBFI_ID_LS 4'h6
`define USBFI_ID_RDA 4'h4
`define USBFI_ID_TO 4'hc
`define USBFI_ID_TX_HOLDING_EMPTY 4'h2
`define USBFI_ID_MS 4'h0
`define USBFI_ID_NONE 4'h1
// trigger levels in bytes
`define USBFI_TRIG0 5'h01
`define USBFI_TRIG1 5'h04
`define USBFI_TRIG2 5'h08
`define USBFI_TRIG3 5'h0e
// sampling: mid-bit phase of the sixteen-times clock
`define USBFI_SAMPLE 4'h7
`define USBFI_PH_LAST 4'hf
`endif

// [hw/usbfi_pkg.sv]
// types shared by the uart block
// assumes the constants header is included by the design file
package usbfi_pkg;
	// receiver framing states
	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_DATA = 3'b010,
		RX_STOP = 3'b011,
		RX_BRKW = 3'b100
	} usbfi_rx_state_t;
endpackage : usbfi_pkg

// [hw/usbfi_uart.sv]
// uart core: registers, baud generator, fifos, serial and modem logic
// assumes a synchronous processor strobe interface on core_clk
`timescale 1ns/1ps
`include "usbfi_params.svh"
module usbfi_uart #(
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// processor register port
	input wire logic [2:0] addr,
	input wire logic rd_stb,
	input wire logic wr_stb,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic intr,
	// serial line
	input wire logic serial_input_pin,
	output logic sout,
	// modem inputs, active low
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic ri_n,
	input wire logic dcd_n,
	// modem outputs, active low
	output logic dtr_n,
	output logic rts_n,
	output logic aux_output_one_n,
	output logic aux_output_two_n
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] CAP = (AW+1)'(DEPTH);

	// software registers
	logic [7:0] dll, divisor_high_byte, lcr, scratchpad_reg; // divisor, format, scratch
	logic [5:0] interrupt_enable_reg; // bit 5 enables extended trigger
	logic [4:0] modem_control_reg; // dtr, rts, aux_output_one, aux_output_two, loop
	logic fifo_en; // fifo mode
	logic [1:0] rx_trig, tx_trig; // trigger codes
	wire divisor_access_select = lcr[`USBFI_LCR_DIVISOR_ACCESS_SELECT];
	wire loop = modem_control_reg[`USBFI_MCR_LOOP];

	// trigger code to byte count
	function automatic logic [4:0] lvl(input logic [1:0] c);
		case (c)
			2'b00: lvl = `USBFI_TRIG0;
			2'b01: lvl = `USBFI_TRIG1;
			2'b10: lvl = `USBFI_TRIG2;
			default: lvl = `USBFI_TRIG3;
		endcase
	endfunction : lvl

	// parity bit for the programmed mode, data already masked
	function automatic logic par(input logic [7:0] d, input logic [7:0] l);
		par = l[5] ? ~l[4] : (^d ^ ~l[4]);
	endfunction : par

	// access decode; shared addresses steer on the access bit
	wire wr_thr = wr_stb && addr == `USBFI_ADR_DATA && !divisor_access_select;
	wire rd_rbr = rd_stb && addr == `USBFI_ADR_DATA && !divisor_access_select;
	wire div_wr = wr_stb && divisor_access_select && addr[2:1] == 2'b00;
	wire rd_lsr = rd_stb && addr == `USBFI_ADR_LSR;
	wire rd_msr = rd_stb && addr == `USBFI_ADR_MSR;
	wire rd_iir = rd_stb && addr == `USBFI_ADR_IIR;
	wire wr_fcr = wr_stb && addr == `USBFI_ADR_IIR;
	wire [15:0] wr_div = {addr[0] ? wdata : divisor_high_byte, addr[0] ? dll : wdata};

	// frame length in sample clocks from the current format
	wire [3:0] wl = 4'd5 + {2'b00, lcr[1:0]};
	wire [3:0] nbits = wl + 4'd2 + {3'b000, lcr[3]};
	wire [8:0] half = (lcr[1:0] == 2'b00) ? 9'd8 : 9'd16;
	wire [8:0] chr_t = {1'b0, nbits, 4'h0} + (lcr[2] ? half : 9'd0);
	wire [7:0] dmask = 8'hff >> (2'd3 - lcr[1:0]);

	// register writes; fifo mode change also flushes both fifos
	wire flush_rx = wr_fcr && (wdata[1] || wdata[0] != fifo_en);
	wire flush_tx = wr_fcr && (wdata[2] || wdata[0] != fifo_en);
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			{divisor_high_byte, dll} <= `USBFI_DIV_RST;
			lcr <= `USBFI_LCR_RST;
			{interrupt_enable_reg, modem_control_reg, scratchpad_reg, fifo_en, rx_trig, tx_trig} <= '0;
		end else if (wr_stb) begin
			case (addr)
				`USBFI_ADR_DATA: if (divisor_access_select) dll <= wdata;
				`USBFI_ADR_IER: if (divisor_access_select) divisor_high_byte <= wdata;
					else interrupt_enable_reg <= wdata[5:0];
				`USBFI_ADR_IIR: begin
					fifo_en <= wdata[0];
					rx_trig <= wdata[7:6];
					tx_trig <= wdata[5:4];
				end
				`USBFI_ADR_LCR: lcr <= wdata;
				`USBFI_ADR_MCR: modem_control_reg <= wdata[4:0];
				`USBFI_ADR_SCR: scratchpad_reg <= wdata; // no side effect
				default: ;
			endcase
		end
	end

	// baud generator: one tick per divisor count
	logic [15:0] bcnt;
	wire tick = bcnt <= 16'h0001;
	always_ff @(posedge core_clk) begin
		if (sys_rst) bcnt <= `USBFI_DIV_RST;
		else if (div_wr) bcnt <= wr_div; // no long first count
		else if (tick) bcnt <= {divisor_high_byte, dll};
		else bcnt <= bcnt - 16'h0001;
	end

	// two-flop synchronisers for serial and modem pins
	logic [4:0] sy1, sy2;
	always_ff @(posedge core_clk) begin
		if (sys_rst) {sy2, sy1} <= 10'h3ff;
		else {sy2, sy1} <= {sy1, dcd_n, ri_n, dsr_n, cts_n, serial_input_pin};
	end

	// modem status: [3]=dcd [2]=ri [1]=dsr [0]=cts
	logic [3:0] mprev, mdelta;
	wire [3:0] mnow = loop ? {modem_control_reg[3], modem_control_reg[2], modem_control_reg[0], modem_control_reg[1]}
		: ~sy2[4:1];
	wire [3:0] mchg = {mnow[3] ^ mprev[3], mprev[2] & ~mnow[2],
		mnow[1:0] ^ mprev[1:0]};
	always_ff @(posedge core_clk) begin
		if (sys_rst) {mprev, mdelta} <= '0;
		else begin
			mprev <= mnow;
			mdelta <= (rd_msr ? 4'h0 : mdelta) | mchg; // set wins
		end
	end

	// transmit fifo; character mode holds a single byte
	logic [7:0] txq [DEPTH];
	logic [AW-1:0] twp, trp;
	logic [AW:0] tx_cnt;
	logic [11:0] tsh; // frame shifter, lsb first
	logic [8:0] tcnt;
	logic tbusy;
	wire [AW:0] tx_cap = fifo_en ? CAP : (AW+1)'(1);
	wire tx_push = wr_thr && tx_cnt != tx_cap;
	wire tx_load = !tbusy && tx_cnt != '0;
	wire [7:0] td = txq[trp] & dmask;
	wire txo = tbusy ? tsh[0] : 1'b1;
	logic [11:0] frame;
	always_comb begin
		frame = 12'hfff;
		frame[0] = 1'b0;
		for (int i = 0; i < 8; i++)
			if (4'(i) < wl) frame[i+1] = td[i];
		if (lcr[3]) frame[wl+4'd1] = par(td, lcr);
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst || flush_tx) {twp, trp, tx_cnt} <= '0;
		else begin
			if (tx_push) txq[twp] <= wdata;
			twp <= twp + AW'(tx_push);
			trp <= trp + AW'(tx_load);
			tx_cnt <= tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_load);
		end
	end
	// shifter: one bit per sixteen ticks, frame ends after chr_t ticks
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			{tbusy, tcnt} <= '0;
			tsh <= 12'hfff;
		end else if (tx_load) begin
			{tbusy, tcnt, tsh} <= {1'b1, 9'h000, frame};
		end else if (tbusy && tick) begin
			tcnt <= tcnt + 9'h001;
			if (tcnt[3:0] == `USBFI_PH_LAST) tsh <= {1'b1, tsh[11:1]};
			if (tcnt == chr_t - 9'h001) tbusy <= 1'b0;
		end
	end
	wire [4:0] trig_tx = interrupt_enable_reg[`USBFI_IER_EXT] ? lvl(tx_trig)
		: `USBFI_TRIG0;
	wire tx_holding_empty = fifo_en ? 5'(tx_cnt) < trig_tx : tx_cnt == '0;
	wire tx_all_empty = tx_cnt == '0 && !tbusy;

	// receiver framing
	usbfi_pkg::usbfi_rx_state_t st;
	logic [3:0] ph, idx;
	logic [8:0] rsh;
	logic anyone; // any one bit seen since start
	wire rx_line = loop ? txo : sy2[0];
	wire [3:0] dbits = wl + {3'b000, lcr[3]};
	wire rx_done = st == usbfi_pkg::RX_STOP && tick && ph == `USBFI_SAMPLE;
	wire rx_brk = !rx_line && !anyone;
	wire [7:0] rd_d = rsh[7:0] & dmask;
	wire rx_pe = lcr[3] && rsh[wl] != par(rd_d, lcr);
	wire [10:0] rx_word = rx_brk ? 11'h600 // one zero char
		: {1'b0, !rx_line, rx_pe, rd_d};
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st <= usbfi_pkg::RX_IDLE;
			{ph, idx, rsh, anyone} <= '0;
		end else case (st)
			usbfi_pkg::RX_IDLE: if (!rx_line) begin
				st <= usbfi_pkg::RX_START;
				ph <= 4'h0;
			end
			usbfi_pkg::RX_START: if (tick) begin
				ph <= ph + 4'h1;
				if (ph == `USBFI_SAMPLE && rx_line) st <= usbfi_pkg::RX_IDLE;
				if (ph == `USBFI_PH_LAST) begin
					st <= usbfi_pkg::RX_DATA;
					{idx, rsh, anyone} <= '0;
				end
			end
			usbfi_pkg::RX_DATA: if (tick) begin
				ph <= ph + 4'h1;
				if (ph == `USBFI_SAMPLE) begin
					rsh[idx] <= rx_line;
					anyone <= anyone | rx_line;
					idx <= idx + 4'h1;
				end
				if (ph == `USBFI_PH_LAST && idx == dbits)
					st <= usbfi_pkg::RX_STOP;
			end
			// bad stop becomes the next start, phase runs on
			usbfi_pkg::RX_STOP: if (tick) begin
				ph <= ph + 4'h1;
				if (ph == `USBFI_SAMPLE)
					st <= rx_brk ? usbfi_pkg::RX_BRKW : rx_line
						? usbfi_pkg::RX_IDLE : usbfi_pkg::RX_START;
			end
			// no new character until the line marks
			usbfi_pkg::RX_BRKW: if (rx_line) st <= usbfi_pkg::RX_IDLE;
			default: st <= usbfi_pkg::RX_IDLE;
		endcase
	end

	// two-entry buffer between receiver and fifo; a word arriving with both entries full is lost
	logic [10:0] sk0, sk1;
	logic [1:0] sk_cnt;
	logic [10:0] rxq [DEPTH];
	logic [AW-1:0] rwp, rrp;
	logic [AW:0] rx_cnt;
	wire [AW:0] rx_cap = fifo_en ? CAP : (AW+1)'(1);
	wire sk_in = rx_done && sk_cnt != 2'd2;
	wire sk_out = sk_cnt != 2'd0 && rx_cnt != rx_cap;
	wire [1:0] sk_left = sk_cnt - 2'(sk_out);
	always_ff @(posedge core_clk) begin
		if (sys_rst || flush_rx) sk_cnt <= 2'd0;
		else begin
			if (sk_out) sk0 <= sk1;
			if (sk_in && sk_left == 2'd0) sk0 <= rx_word;
			if (sk_in && sk_left != 2'd0) sk1 <= rx_word;
			sk_cnt <= sk_left + 2'(sk_in);
		end
	end

	// receive fifo with head tracking and queued error count
	wire rx_pop = rd_rbr && rx_cnt != '0;
	wire [10:0] head = rxq[rrp];
	logic head_seen; // head flags already moved to status
	logic [AW:0] err_cnt;
	wire reveal = rx_cnt != '0 && !head_seen && !rx_pop;
	wire sk_err = |sk0[10:8];
	wire hd_err = |head[10:8];
	always_ff @(posedge core_clk) begin
		if (sys_rst || flush_rx) {rwp, rrp, rx_cnt, err_cnt, head_seen} <= '0;
		else begin
			if (sk_out) rxq[rwp] <= sk0;
			rwp <= rwp + AW'(sk_out);
			rrp <= rrp + AW'(rx_pop);
			rx_cnt <= rx_cnt + (AW+1)'(sk_out) - (AW+1)'(rx_pop);
			err_cnt <= err_cnt + (AW+1)'(sk_out && sk_err)
				- (AW+1)'(rx_pop && hd_err);
			head_seen <= rx_pop ? 1'b0 : (head_seen | reveal);
		end
	end

	// line status flags, set wins over the read clear
	logic oe, pe, fe, bi;
	always_ff @(posedge core_clk) begin
		if (sys_rst) {oe, pe, fe, bi} <= '0;
		else begin
			oe <= (oe & !rd_lsr) | (rx_done && sk_cnt == 2'd2);
			pe <= (pe & !rd_lsr) | (reveal & head[8]);
			fe <= (fe & !rd_lsr) | (reveal & head[9]);
			bi <= (bi & !rd_lsr) | (reveal & head[10]);
		end
	end
	wire dr = rx_cnt != '0;
	wire [7:0] line_status_reg = {fifo_en && err_cnt != '0, tx_all_empty, tx_holding_empty, bi, fe, pe,
		oe, dr};

	// character timeout over four frame times of ticks
	logic [10:0] to_cnt;
	logic to_flag;
	wire to_rst = sk_out || rx_pop || rx_cnt == '0;
	always_ff @(posedge core_clk) begin
		if (sys_rst) {to_cnt, to_flag} <= '0;
		else begin
			if (to_rst) to_cnt <= 11'h000;
			else if (tick && !to_flag) to_cnt <= to_cnt + 11'h001;
			if (rx_pop) to_flag <= 1'b0;
			else if (!to_rst && to_cnt == {chr_t, 2'b00})
				to_flag <= 1'b1;
		end
	end

	// transmit interrupt with first-empty delay
	logic tx_holding_empty_irq, tx_holding_empty_q, two_seen, first_imm, dly_on;
	logic [8:0] dly;
	wire tx_holding_empty_c = tx_holding_empty && interrupt_enable_reg[1];
	wire tx_holding_empty_rise = tx_holding_empty_c && !tx_holding_empty_q;
	wire [3:0] iid;
	wire iir_tx_holding_empty = rd_iir && iid == `USBFI_ID_TX_HOLDING_EMPTY;
	wire dly_end = dly_on && dly == chr_t - 9'd16; // delay has run out
	always_ff @(posedge core_clk) begin
		if (sys_rst) {tx_holding_empty_irq, tx_holding_empty_q, two_seen, first_imm, dly_on, dly} <= '0;
		else begin
			tx_holding_empty_q <= tx_holding_empty_c;
			first_imm <= (first_imm & !tx_holding_empty_rise)
				| (wr_fcr && wdata[0] != fifo_en); // fifo toggle
			two_seen <= (two_seen & !tx_holding_empty_rise) | tx_cnt >= (AW+1)'(2);
			// the delay runs once; a free count would wrap and raise
			// the request again after the identification read
			dly_on <= tx_holding_empty_c && (dly_on && !dly_end
				|| tx_holding_empty_rise && !two_seen && !first_imm);
			dly <= (dly_on && tick) ? dly + 9'h001 : (dly_on ? dly : 9'h000);
			if (tx_holding_empty_rise && (two_seen || first_imm))
				tx_holding_empty_irq <= 1'b1;
			else if (dly_end)
				tx_holding_empty_irq <= 1'b1;
			else if (!tx_holding_empty_c || iir_tx_holding_empty) tx_holding_empty_irq <= 1'b0;
		end
	end

	// interrupt priority; cleared enables give polled mode
	wire p_ls = interrupt_enable_reg[2] && (oe || pe || fe || bi);
	wire p_rda = interrupt_enable_reg[0] && (fifo_en ? 5'(rx_cnt) >= lvl(rx_trig) : dr);
	wire p_to = interrupt_enable_reg[0] && fifo_en && to_flag;
	wire p_ms = interrupt_enable_reg[3] && mdelta != 4'h0;
	assign iid = p_ls ? `USBFI_ID_LS : p_rda ? `USBFI_ID_RDA
		: p_to ? `USBFI_ID_TO : tx_holding_empty_irq ? `USBFI_ID_TX_HOLDING_EMPTY
		: p_ms ? `USBFI_ID_MS : `USBFI_ID_NONE;

	// read mux and registered outputs
	wire [7:0] rmux = addr == `USBFI_ADR_DATA ? (divisor_access_select ? dll : head[7:0])
		: addr == `USBFI_ADR_IER ? (divisor_access_select ? divisor_high_byte : {2'b00, interrupt_enable_reg})
		: addr == `USBFI_ADR_IIR ? {fifo_en, fifo_en, 2'b00, iid}
		: addr == `USBFI_ADR_LCR ? lcr : addr == `USBFI_ADR_MCR
		? {3'b000, modem_control_reg} : addr == `USBFI_ADR_LSR ? line_status_reg
		: addr == `USBFI_ADR_MSR ? {mnow, mdelta} : scratchpad_reg;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			{rdata, intr} <= '0;
			{sout, dtr_n, rts_n, aux_output_one_n, aux_output_two_n} <= 5'h1f;
		end else begin
			if (rd_stb) rdata <= rmux;
			intr <= !iid[0];
			sout <= loop || (!lcr[`USBFI_LCR_BRK] && txo);
			{aux_output_two_n, aux_output_one_n, rts_n, dtr_n} <=
				loop ? 4'hf : ~modem_control_reg[3:0]; // pins idle in loopback
		end
	end

	// checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	a_overrun_flag: assert property (rx_done && sk_cnt == 2'd2 |=> oe
		&& sk_cnt != 2'd0) else $error("overrun not flagged");
	a_parity_head: assert property (reveal && head[8] && !rd_lsr |=> pe)
		else $error("parity not shown");
	a_frame_resync: assert property (rx_done && !rx_line && anyone |=>
		st == usbfi_pkg::RX_START && ph == 4'h8)
		else $error("no resync");
	a_break_zero: assert property (rx_done && rx_brk |-> rx_word[7:0]
		== 8'h00 ##1 st == usbfi_pkg::RX_BRKW)
		else $error("break char wrong");
	a_tx_holding_empty_clear: assert property (wr_thr && !fifo_en && tx_cnt == '0 &&
		!flush_tx |=> !line_status_reg[5] && !line_status_reg[6]) else $error("tx_holding_empty stuck");
	a_msr_delta: assert property (mchg[0] && !rd_msr |=> mdelta[0] ##1
		mdelta[0] || $past(rd_msr)) else $error("delta lost");
	a_div_reload: assert property (div_wr |=> bcnt == $past(wr_div))
		else $error("divisor not reloaded");
	a_ls_first: assert property (p_ls && rd_iir |=> rdata[3:0] ==
		`USBFI_ID_LS) else $error("priority wrong");
	a_timeout_clr: assert property (rx_pop && to_flag |=> !to_flag &&
		to_cnt == 11'h000) else $error("timeout not cleared");
	a_delay_once: assert property (dly_end |=> !dly_on)
		else $error("delay count ran on");
	c_break: cover property (rx_done && rx_brk);
	c_timeout: cover property (p_to && rd_iir);
	c_tx_holding_empty_delay: cover property (dly_on && dly == chr_t - 9'd16);
endmodule : usbfi_uart
